// ---- hdl/ppc_counter.sv ----
// Prescaled up/down pulse counter with register port and count store.
// Assumes pins arrive asynchronously and an outside store keeps the
// count across power loss, handed back through the restore port.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ppc_counter (
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	input  wire logic        COUNT_IN,
	input  wire logic        COUNT_RST_N_IN,
	input  wire logic        NV_LOAD,
	input  wire logic [15:0] NV_LOAD_DATA,
	output logic             NV_STORE,
	output logic      [15:0] NV_DATA,
	output logic      [15:0] COUNT_VALUE,
	output logic             LIMIT_ERROR
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic               mode_down_ff;  // count_down_mode when set
	logic               edge_fall_ff;  // falling_edge_select when set
	ppc_pkg::ppc_policy_t policy_ff;   // Limit policy
	logic        [9:0]  div_ff;        // Prescale factor
	logic        [13:0] upper_ff;      // upper_count_limit
	logic signed [15:0] count_ff;      // Present count
	logic signed [15:0] nxt_count;     // Next count
	logic               err_ff;        // Sticky limit error
	logic               nxt_err_set;   // Excursion this cycle
	logic        [9:0]  pre_ff;        // Prescaler remainder
	logic               store_ff;      // Count changed pulse
	logic        [31:0] rdata_ff;      // Read answer
	logic               pin_rise;      // Count pin rising edge
	logic               pin_fall;      // Count pin falling edge
	logic               rst_level;     // Filtered reset pin level
	logic               rst_held;      // Reset pin tied to ground
	logic               qual_edge;     // Edge of selected polarity
	logic               step;          // One counter step
	logic signed [15:0] start_val;     // Value after reset pin
	logic               wr_ctrl;       // Write strobes per register
	logic               wr_div;
	logic               wr_upper;
	logic               wr_status;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Clamp a written divisor into the legal prescale range
	function automatic logic [9:0] fit_div(input logic [31:0] v);
		if (v < 32'(ppc_pkg::DIV_MIN)) begin
			return ppc_pkg::DIV_MIN;
		end else if (v > 32'(ppc_pkg::DIV_MAX)) begin
			return ppc_pkg::DIV_MAX;
		end
		return v[9:0];
	endfunction

	// One counting step under the limit policy; top bit is excursion
	function automatic logic [16:0] step_value(
		input logic signed [15:0] c,
		input logic               down,
		input ppc_pkg::ppc_policy_t pol,
		input logic signed [15:0] hi
	);
		logic signed [15:0] lo;
		lo = signed'(ppc_pkg::LOWER_LIMIT);
		if (pol == ppc_pkg::PPC_LIM_OFF) begin
			// Only the measuring range stops the count
			if (!down) begin
				return {1'b0, (c >= signed'(ppc_pkg::RANGE_MAX)) ?
					signed'(ppc_pkg::RANGE_MAX) : 16'(c + 16'sh0001)};
			end
			return {1'b0, (c <= signed'(ppc_pkg::RANGE_MIN)) ?
				signed'(ppc_pkg::RANGE_MIN) : 16'(c - 16'sh0001)};
		end
		// Bounded policies hold at the limit and report the excursion
		if (!down) begin
			if (c >= hi) begin
				return {1'b1, hi};
			end
			return {1'b0, 16'(c + 16'sh0001)};
		end
		if (c <= lo) begin
			return {1'b1, lo};
		end
		return {1'b0, 16'(c - 16'sh0001)};
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------

	// Count pin, idles high as with a pulled-up contact
	ppc_pin_sync #(.IDLE_LEVEL(1'b1)) u_count_sync (
		.clk   (SYS_CLK),
		.rst_n (RST_N),
		.pin   (COUNT_IN),
		.level (),
		.rise  (pin_rise),
		.fall  (pin_fall)
	);

	// Reset pin, released (high) when open
	ppc_pin_sync #(.IDLE_LEVEL(1'b1)) u_rst_sync (
		.clk   (SYS_CLK),
		.rst_n (RST_N),
		.pin   (COUNT_RST_N_IN),
		.level (rst_level),
		.rise  (),
		.fall  ()
	);

	assign rst_held  = !rst_level;
	assign qual_edge = edge_fall_ff ? pin_fall : pin_rise;
	assign step      = qual_edge && (pre_ff >= 10'(div_ff - 10'h001));
	// Down mode starts from the upper limit, up mode from zero
	assign start_val = mode_down_ff ? signed'({2'b00, upper_ff}) :
		signed'(ppc_pkg::COUNT_RESET);

	// ----------------------------------------------------------------
	// Register write decode
	// ----------------------------------------------------------------
	assign wr_ctrl   = REG_WR && (REG_ADDR == ppc_pkg::OFS_CTRL);
	assign wr_div    = REG_WR && (REG_ADDR == ppc_pkg::OFS_DIV);
	assign wr_upper  = REG_WR && (REG_ADDR == ppc_pkg::OFS_UPPER);
	assign wr_status = REG_WR && (REG_ADDR == ppc_pkg::OFS_STATUS);

	// Configuration fields
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_down_ff <= 1'b0;
			edge_fall_ff <= 1'b0;
			policy_ff    <= ppc_pkg::POLICY_RESET;
		end else if (wr_ctrl) begin
			mode_down_ff <= REG_WDATA[ppc_pkg::CTRL_MODE_BIT];
			edge_fall_ff <= REG_WDATA[ppc_pkg::CTRL_EDGE_BIT];
			// Unused encoding falls back to the tolerant policy
			case (REG_WDATA[ppc_pkg::CTRL_POLICY_LSB +: 2])
				2'h1:    policy_ff <= ppc_pkg::PPC_LIM_ERR;
				2'h3:    policy_ff <= ppc_pkg::PPC_LIM_CLAMP;
				default: policy_ff <= ppc_pkg::PPC_LIM_OFF;
			endcase
		end
	end

	// Prescale factor, forced into 1..1000
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			div_ff <= ppc_pkg::DIV_RESET;
		end else if (wr_div) begin
			div_ff <= fit_div(REG_WDATA);
		end
	end

	// Upper limit, forced into 0..9999
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			upper_ff <= ppc_pkg::UPPER_RESET;
		end else if (wr_upper) begin
			if (REG_WDATA > 32'(ppc_pkg::UPPER_MAX)) begin
				upper_ff <= ppc_pkg::UPPER_MAX;
			end else begin
				upper_ff <= REG_WDATA[13:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------

	// Remainder is dropped while the reset pin is held, so a
	// restart never inherits a half-finished group
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pre_ff <= 10'h000;
		end else if (rst_held) begin
			pre_ff <= 10'h000;
		end else if (step) begin
			pre_ff <= 10'h000;
		end else if (qual_edge) begin
			pre_ff <= 10'(pre_ff + 10'h001);
		end
	end

	// ----------------------------------------------------------------
	// Count
	// ----------------------------------------------------------------

	// Next count: reset pin wins, then restore, then a step
	always_comb begin
		logic [16:0] sv;
		sv          = step_value(count_ff, mode_down_ff, policy_ff,
			signed'({2'b00, upper_ff}));
		nxt_count   = count_ff;
		nxt_err_set = 1'b0;
		if (rst_held) begin
			nxt_count = start_val;
		end else if (NV_LOAD) begin
			nxt_count = signed'(NV_LOAD_DATA);
		end else if (step) begin
			nxt_count = signed'(sv[15:0]);
			// Only the error policy raises the flag
			nxt_err_set = sv[16] && (policy_ff == ppc_pkg::PPC_LIM_ERR);
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			count_ff <= signed'(ppc_pkg::COUNT_RESET);
		end else begin
			count_ff <= nxt_count;
		end
	end

	// Sticky error; an excursion in the clearing cycle still sets it
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			err_ff <= 1'b0;
		end else if (nxt_err_set) begin
			err_ff <= 1'b1;
		end else if (rst_held) begin
			err_ff <= 1'b0;
		end else if (wr_status && REG_WDATA[ppc_pkg::STAT_ERR_BIT]) begin
			err_ff <= 1'b0;
		end
	end

	// Store pulse whenever the count moves, except in a restore cycle, for the keeping memory
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			store_ff <= 1'b0;
		end else begin
			store_ff <= (nxt_count != count_ff) && !NV_LOAD;
		end
	end

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------

	// Answer stands one cycle only; unmapped reads return zero
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_ff <= 32'h0000_0000;
		end else if (REG_RD) begin
			case (REG_ADDR)
				ppc_pkg::OFS_CTRL:   rdata_ff <= {28'h000_0000, policy_ff,
					edge_fall_ff, mode_down_ff};
				ppc_pkg::OFS_DIV:    rdata_ff <= {22'h00_0000, div_ff};
				ppc_pkg::OFS_UPPER:  rdata_ff <= {18'h0_0000, upper_ff};
				ppc_pkg::OFS_COUNT:  rdata_ff <= {{16{count_ff[15]}}, count_ff};
				ppc_pkg::OFS_STATUS: rdata_ff <= {30'h0000_0000, rst_held, err_ff};
				default:             rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	assign REG_RDATA   = rdata_ff;
	assign NV_STORE    = store_ff;
	assign NV_DATA     = count_ff;
	assign COUNT_VALUE = count_ff;
	assign LIMIT_ERROR = err_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	chk_reset_hold: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		rst_held |=> (count_ff == $past(start_val)) && (pre_ff == 10'h000))
		else $error("count not held at start value under reset pin");

	chk_up_step: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(step && !rst_held && !NV_LOAD && !mode_down_ff &&
			count_ff < signed'({2'b00, upper_ff}))
		|=> count_ff == 16'($past(count_ff) + 16'sh0001))
		else $error("up step did not add one");

	chk_down_step: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(step && !rst_held && !NV_LOAD && mode_down_ff && count_ff > 16'sh0000)
		|=> count_ff == 16'($past(count_ff) - 16'sh0001))
		else $error("down step did not subtract one");

	chk_nv_restore: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(NV_LOAD && !rst_held) |=> (count_ff == $past(NV_LOAD_DATA)) && !NV_STORE)
		else $error("stored count not resumed");

	chk_edge_only: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		((edge_fall_ff ? pin_rise : pin_fall) && !rst_held) |=> $stable(pre_ff))
		else $error("edge of the other polarity moved the prescaler");

	chk_edge_hold: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(!qual_edge && !rst_held && !NV_LOAD) |=> $stable(count_ff) && $stable(err_ff)
			|| $past(wr_status))
		else $error("count moved without a selected edge");

	chk_group_end: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		step |=> pre_ff == 10'h000)
		else $error("prescaler not emptied after a step");

	chk_upper_range: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(upper_ff <= ppc_pkg::UPPER_MAX) && (div_ff >= ppc_pkg::DIV_MIN) &&
			(div_ff <= ppc_pkg::DIV_MAX))
		else $error("limit or divisor out of range");

	chk_range_end: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(count_ff <= signed'(ppc_pkg::RANGE_MAX)) &&
			(count_ff >= signed'(ppc_pkg::RANGE_MIN)))
		else $error("count left the measuring range");

	chk_err_raise: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(step && !rst_held && !NV_LOAD && policy_ff == ppc_pkg::PPC_LIM_ERR &&
			!mode_down_ff && count_ff >= signed'({2'b00, upper_ff}))
		|=> err_ff && (count_ff == signed'({2'b00, $past(upper_ff)})))
		else $error("overflow under error policy not flagged");

	chk_clamp_floor: assert property (
		@(posedge SYS_CLK) disable iff (!RST_N)
		(step && !rst_held && !NV_LOAD && policy_ff == ppc_pkg::PPC_LIM_CLAMP &&
			mode_down_ff && count_ff <= 16'sh0000)
		|=> (count_ff == 16'sh0000) && (err_ff == $past(err_ff) || !err_ff))
		else $error("underflow under clamp policy not held at zero");

endmodule

`default_nettype wire

// ---- hdl/ppc_pkg.sv ----
// Constants, register map and field layout of the pulse counter.
// Assumes a single 50 MHz system clock and a plain strobe register port.
//
// Overview of operation
// - Up mode starts at zero, counts up
// - Down mode loads upper limit, counts down
// - Held reset pin keeps start value; release restarts
// - Count survives power loss, resumes from store
// - Selected edge polarity alone advances prescaler
// - Prescale 1..1000; one step per group
// - Upper limit 0..9999, lower fixed zero
// - Limits off: run to measuring range end
// - Error policy: bounded count, flag excursions
// - Clamp policy: show limit or zero instead

package ppc_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00; // Mode, edge, policy
	localparam logic [7:0] OFS_DIV    = 8'h04; // Prescale factor
	localparam logic [7:0] OFS_UPPER  = 8'h08; // Upper counting limit
	localparam logic [7:0] OFS_COUNT  = 8'h0c; // Present count, read only
	localparam logic [7:0] OFS_STATUS = 8'h10; // Error and pin state

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_BIT    = 0; // 1 = count_down_mode
	localparam int CTRL_EDGE_BIT    = 1; // 1 = falling_edge_select
	localparam int CTRL_POLICY_LSB  = 2; // Two-bit limit policy
	localparam int STAT_ERR_BIT     = 0; // Limit error, write 1 clears
	localparam int STAT_HELD_BIT    = 1; // Reset pin held low

	// ----------------------------------------------------------------
	// Ranges and reset values
	// ----------------------------------------------------------------
	localparam logic [9:0]  DIV_MIN       = 10'h001; // Smallest factor
	localparam logic [9:0]  DIV_MAX       = 10'h3e8; // 1000
	localparam logic [13:0] UPPER_MAX     = 14'h270f; // 9999
	localparam logic [9:0]  DIV_RESET     = 10'h001;
	localparam logic [13:0] UPPER_RESET   = 14'h270f;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [15:0] LOWER_LIMIT   = 16'h0000; // Fixed floor
	localparam logic [15:0] RANGE_MAX     = 16'h270f; // Measuring top, 9999
	localparam logic [15:0] RANGE_MIN     = 16'hf831; // Measuring floor, -1999

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PPC_LIM_OFF   = 2'h0, // Tolerate, run to measuring range
		PPC_LIM_ERR   = 2'h1, // limit_error_policy
		PPC_LIM_CLAMP = 2'h3  // Clamp to limit or zero
	} ppc_policy_t;

	localparam ppc_policy_t POLICY_RESET = PPC_LIM_OFF;

endpackage

// ---- hdl/ppc_pin_sync.sv ----
// Three-stage pin synchroniser with filtered level and edge pulses.
// Assumes the pin is asynchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none

module ppc_pin_sync #(
	parameter logic IDLE_LEVEL = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	logic s1_ff;    // Metastable stage, read only by s2
	logic s2_ff;    // Second stage
	logic s3_ff;    // Third stage
	logic level_ff; // Accepted level

	// ----------------------------------------------------------------
	// Synchroniser chain
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= IDLE_LEVEL;
			s2_ff <= IDLE_LEVEL;
			s3_ff <= IDLE_LEVEL;
		end else begin
			s1_ff <= pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Accept a change only once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_ff <= IDLE_LEVEL;
		end else if (s2_ff == s3_ff) begin
			level_ff <= s3_ff;
		end
	end

	// Edges are taken where the accepted level is about to move
	assign level = level_ff;
	assign rise  = (s2_ff == s3_ff) && s3_ff && !level_ff;
	assign fall  = (s2_ff == s3_ff) && !s3_ff && level_ff;

endmodule

`default_nettype wire

// ---- bench/ppc_pulse_src.sv ----
// Far-side model: pulse transmitter or switching contact on the count pins.
// Assumes the bench calls its tasks; both lines idle high, as with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module ppc_pulse_src (
	input  wire logic clk,
	output logic      pulse_out,
	output logic      rst_pin_n
);
	// ----------------------------------------------------------------
	// Line levels
	// ----------------------------------------------------------------
	initial begin
		pulse_out = 1'b1; // Idle high, pull-up on the pin
		rst_pin_n = 1'b1; // Reset contact open
	end

	// One level change, held long enough for the filter to agree
	task automatic set_level(input logic v);
		@(posedge clk);
		pulse_out <= v;
		repeat (4) @(posedge clk);
	endtask

	// Whole pulses, low then high, so the line always ends idle
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			set_level(1'b0);
			set_level(1'b1);
		end
	endtask

	// Contact level, held long enough for the filter to take it
	task automatic set_contact(input logic v);
		@(posedge clk);
		rst_pin_n <= v;
		repeat (6) @(posedge clk);
	endtask

	// Contact closes to ground; the count must sit at its start
	task automatic press();
		set_contact(1'b0);
	endtask

	// Contact opens; counting starts over
	task automatic release_rst();
		set_contact(1'b1);
	endtask
endmodule

`default_nettype wire

// ---- bench/test_ppc_counter.sv ----
// Self-checking bench for the prescaled pulse counter.
// Assumes the pulse source model drives both pins; reads checked from a queue.
`timescale 1ns/1ps
`default_nettype none

module test_ppc_counter;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        SYS_CLK;      // 50 MHz
	logic        RST_N;        // Block reset
	logic [7:0]  REG_ADDR;     // Register address
	logic [31:0] REG_WDATA;    // Write data
	logic        REG_WR;       // Write strobe
	logic        REG_RD;       // Read strobe
	logic [31:0] REG_RDATA;    // Read data
	logic        COUNT_IN;     // Pulse line
	logic        COUNT_RST_N_IN; // Reset contact
	logic        NV_LOAD;      // Restore strobe
	logic [15:0] NV_LOAD_DATA; // Restore value
	logic        NV_STORE;     // Store request
	logic [15:0] NV_DATA;      // Value to keep
	logic [15:0] COUNT_VALUE;  // Present count
	logic        LIMIT_ERROR;  // Limit error
	int          n_errors = 0; // Mismatches
	int          checked = 0;  // Comparisons
	int          n_store = 0;  // Store pulses seen
	int          cycles = 0;   // Hang guard
	logic        rd_seen = 1'b0; // Read issued last edge
	logic [31:0] exp_q[$];     // Expected read data
	string       name_q[$];    // What each read was

	// ----------------------------------------------------------------
	// Design and far side
	// ----------------------------------------------------------------
	ppc_counter uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .COUNT_IN(COUNT_IN), .COUNT_RST_N_IN(COUNT_RST_N_IN),
		.NV_LOAD(NV_LOAD), .NV_LOAD_DATA(NV_LOAD_DATA), .NV_STORE(NV_STORE),
		.NV_DATA(NV_DATA), .COUNT_VALUE(COUNT_VALUE), .LIMIT_ERROR(LIMIT_ERROR));
	ppc_pulse_src src (.clk(SYS_CLK), .pulse_out(COUNT_IN), .rst_pin_n(COUNT_RST_N_IN));

	initial begin
		SYS_CLK = 1'b0;
		forever #10 SYS_CLK = ~SYS_CLK;
	end

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		if (n_errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge SYS_CLK) begin
		if (rd_seen) begin
			check(name_q.pop_front(), REG_RDATA, exp_q.pop_front());
		end
		rd_seen <= REG_RD;
	end

	// Store pulses and hang guard; ceiling well above the run length
	always @(posedge SYS_CLK) begin
		if (NV_STORE === 1'b1) begin
			n_store++;
		end
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	// One strobe cycle; w picks write or read, never both
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= w;
		REG_RD <= !w;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
		REG_RD <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	// Note the expectation, then strobe once
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
		exp_q.push_back(e);
		name_q.push_back(what);
		bus(1'b0, a, 32'h0);
	endtask

	// Restore strobe from the keeping memory, one cycle
	task automatic restore(input logic [15:0] v, input logic go);
		@(posedge SYS_CLK);
		NV_LOAD <= go;
		NV_LOAD_DATA <= v;
		@(posedge SYS_CLK);
		NV_LOAD <= 1'b0;
	endtask

	// Pin path is a few cycles deep; give it margin
	task automatic settle();
		repeat (8) @(posedge SYS_CLK);
	endtask

	// ----------------------------------------------------------------
	// Limit policy table: ctrl, count, error, upper; pulses are upper plus two
	// ----------------------------------------------------------------
	logic [31:0] t_ctrl[7] = '{32'h0c, 32'h0d, 32'h05, 32'h04, 32'h00, 32'h01, 32'h09};
	logic [31:0] t_cnt[7]  = '{32'h5, 32'h0, 32'h0, 32'h5, 32'h4, 32'hfffffffe, 32'hfffffffe};
	logic [31:0] t_err[7]  = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0};
	int          t_up[7]   = '{5, 5, 5, 5, 2, 2, 2};

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int          n;
		int          k0;
		logic [15:0] d;
		RST_N = 1'b0;
		REG_ADDR = 8'h00;
		REG_WDATA = 32'h0;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		NV_LOAD = 1'b0;
		NV_LOAD_DATA = 16'h0;
		n = $urandom(31);
		repeat (10) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		// Reset values, unmapped place, clamped writes
		rd(ppc_pkg::OFS_CTRL, 32'h0, "ctrl");
		rd(ppc_pkg::OFS_DIV, 32'h1, "div");
		rd(ppc_pkg::OFS_UPPER, 32'h270f, "upper");
		rd(ppc_pkg::OFS_COUNT, 32'h0, "count");
		rd(8'h14, 32'h0, "unmapped");
		wr(ppc_pkg::OFS_DIV, 32'h0);
		rd(ppc_pkg::OFS_DIV, 32'h1, "div_low");
		wr(ppc_pkg::OFS_DIV, 32'h7d0);
		rd(ppc_pkg::OFS_DIV, 32'h3e8, "div_high");
		wr(ppc_pkg::OFS_UPPER, 32'h4e20);
		rd(ppc_pkg::OFS_UPPER, 32'h270f, "upper_high");
		// Divide by three, random pulse count
		wr(ppc_pkg::OFS_DIV, 32'h3);
		n = $urandom_range(12, 1);
		src.pulses(n);
		settle();
		rd(ppc_pkg::OFS_COUNT, n / 3, "prescaled");
		// Partial group, then the contact clears count and remainder
		src.pulses(2);
		src.press();
		rd(ppc_pkg::OFS_STATUS, 32'h2, "held");
		rd(ppc_pkg::OFS_COUNT, 32'h0, "held_count");
		restore(16'($urandom_range(9999, 1)), 1'b1);
		rd(ppc_pkg::OFS_COUNT, 32'h0, "held_restore");
		src.release_rst();
		src.pulses(2);
		settle();
		rd(ppc_pkg::OFS_COUNT, 32'h0, "remainder");
		src.pulses(1);
		settle();
		rd(ppc_pkg::OFS_COUNT, 32'h1, "restart");
		// Edge polarity selection
		wr(ppc_pkg::OFS_DIV, 32'h1);
		src.set_level(1'b0);
		settle();
		rd(ppc_pkg::OFS_COUNT, 32'h1, "fall_ignored");
		src.set_level(1'b1);
		settle();
		rd(ppc_pkg::OFS_COUNT, 32'h2, "rise_counted");
		wr(ppc_pkg::OFS_CTRL, 32'h2);
		src.set_level(1'b0);
		settle();
		rd(ppc_pkg::OFS_COUNT, 32'h3, "fall_counted");
		src.set_level(1'b1);
		settle();
		rd(ppc_pkg::OFS_COUNT, 32'h3, "rise_ignored");
		// Keeping the count: one store per step, restore without store
		k0 = n_store;
		src.pulses(3);
		settle();
		check("stores", n_store - k0, 32'h3);
		check("nv_data", {16'h0, NV_DATA}, 32'h6);
		d = 16'($urandom_range(9999, 0));
		k0 = n_store;
		restore(d, 1'b1);
		settle();
		rd(ppc_pkg::OFS_COUNT, {16'h0, d}, "restored");
		check("restore_stores", n_store - k0, 32'h0);
		// Limit policies in both directions
		for (int i = 0; i < 7; i++) begin
			wr(ppc_pkg::OFS_UPPER, t_up[i]);
			wr(ppc_pkg::OFS_CTRL, t_ctrl[i]);
			src.press();
			rd(ppc_pkg::OFS_COUNT, t_ctrl[i][0] ? t_up[i] : 0, "start");
			src.release_rst();
			src.pulses(t_up[i] + 2);
			settle();
			rd(ppc_pkg::OFS_COUNT, t_cnt[i], "limited");
			check("count_value", {{16{COUNT_VALUE[15]}}, COUNT_VALUE}, t_cnt[i]);
			rd(ppc_pkg::OFS_STATUS, t_err[i], "status");
			check("limit_error", {31'h0, LIMIT_ERROR}, t_err[i]);
			wr(ppc_pkg::OFS_STATUS, 32'h1);
			rd(ppc_pkg::OFS_STATUS, 32'h0, "cleared");
		end
		// Block reset mid-run: settings and count back to reset values
		@(posedge SYS_CLK);
		RST_N <= 1'b0;
		repeat (3) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		rd(ppc_pkg::OFS_CTRL, 32'h0, "ctrl_again");
		rd(ppc_pkg::OFS_UPPER, 32'h270f, "upper_again");
		rd(ppc_pkg::OFS_COUNT, 32'h0, "count_again");
		check("error_again", {31'h0, LIMIT_ERROR}, 32'h0);
		src.pulses(2);
		settle();
		rd(ppc_pkg::OFS_COUNT, 32'h2, "count_after");
		repeat (3) @(posedge SYS_CLK);
		tally_and_finish();
	end
endmodule

`default_nettype wire
